// ### design/sbcp_parser.sv
// byte-stream command parser with register and sample access
`timescale 1ns/1ps
`default_nettype none
module sbcp_parser (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic [7:0]       regAddr,
  output logic [7:0]       regWrData,
  output logic             regWrEn,
  output logic             regRdEn,
  input  wire logic [7:0]  regRdData,
  input  wire logic        regRdValid,
  output logic             sampleReq,
  input  wire logic [15:0] accelX,
  input  wire logic [15:0] accelY,
  input  wire logic [15:0] accelZ,
  input  wire logic        sampleValid,
  input  wire logic [1:0]  buttons,
  output logic             spiTristate
);
  sbcp_pkg::sbcp_pstate_t ps_q;
  sbcp_pkg::sbcp_xstate_t st_q;
  sbcp_pkg::sbcp_mode_t   mode_q;
  logic [1:0] fIdx_q;
  logic [7:0] f_q [4];
  logic       cmdPend_q;
  logic       running_q;
  logic [7:0] rdHold_q;
  logic [7:0] rbuf_q [9];
  logic [3:0] txIdx_q;
  logic       rxReady_q;
  logic       txValid_q;
  logic [7:0] txData_q;
  logic [7:0] regAddr_q;
  logic [7:0] regWrData_q;
  logic       regWrEn_q;
  logic       regRdEn_q;
  logic       sampleReq_q;
  logic       tri_q;
  logic       take;
  logic       frameDone;
  logic       opKnown;
  logic       exec;
  logic       isStop;
  logic       isTriOff;

  assign rxReady     = rxReady_q;
  assign txData      = txData_q;
  assign txValid     = txValid_q;
  assign regAddr     = regAddr_q;
  assign regWrData   = regWrData_q;
  assign regWrEn     = regWrEn_q;
  assign regRdEn     = regRdEn_q;
  assign sampleReq   = sampleReq_q;
  assign spiTristate = tri_q;

  assign take = rxValid && rxReady_q;
  assign frameDone = take && ps_q == sbcp_pkg::PS_FIELD && fIdx_q == 2'd3;
  assign opKnown = rxData == sbcp_pkg::OP_BYTE_WR
                || rxData == sbcp_pkg::OP_BIT_WR
                || rxData == sbcp_pkg::OP_BYTE_RD
                || rxData == sbcp_pkg::OP_BIT_RD
                || rxData == sbcp_pkg::OP_SETTING
                || rxData == sbcp_pkg::OP_ACQ;
  assign exec = st_q == sbcp_pkg::EX_IDLE && cmdPend_q;
  assign isStop = f_q[0] == sbcp_pkg::OP_ACQ && f_q[1] == sbcp_pkg::ACQ_SUB
               && f_q[2] == sbcp_pkg::ACQ_STOP
               && f_q[3] == sbcp_pkg::ACQ_STOP;
  assign isTriOff = f_q[0] == sbcp_pkg::OP_SETTING
                 && f_q[1] == sbcp_pkg::FEAT_TRI
                 && f_q[2] == sbcp_pkg::TRI_OFF_VAL
                 && f_q[3] == sbcp_pkg::TRI_OFF_VAL;

  // frame parser: separator, field, repeated four times
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ps_q <= sbcp_pkg::PS_SEP0;
      fIdx_q <= 2'd0;
      for (int i = 0; i < 4; i++)
        f_q[i] <= sbcp_pkg::FILL_BYTE;
    end
    else if (take)
    begin
      unique case (ps_q)
        sbcp_pkg::PS_SEP0:
          if (rxData == sbcp_pkg::SEP_FIRST)
            ps_q <= sbcp_pkg::PS_SEP1;
          else
            fIdx_q <= 2'd0;
        sbcp_pkg::PS_SEP1:
          if (rxData == sbcp_pkg::SEP_SECOND)
            ps_q <= sbcp_pkg::PS_FIELD;
          else if (rxData != sbcp_pkg::SEP_FIRST)
          begin
            ps_q <= sbcp_pkg::PS_SEP0;
            fIdx_q <= 2'd0;
          end
        sbcp_pkg::PS_FIELD:
        begin
          ps_q <= sbcp_pkg::PS_SEP0;
          f_q[fIdx_q] <= rxData;
          if (fIdx_q == 2'd0 && !opKnown)
            fIdx_q <= 2'd0;
          else
            fIdx_q <= fIdx_q + 2'd1;
        end
      endcase
    end
  end

  // one frame held until the executor takes it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cmdPend_q <= 1'b0;
    else if (frameDone)
      cmdPend_q <= 1'b1;
    else if (exec)
      cmdPend_q <= 1'b0;
  end

  // input stalls while a frame waits or the executor is busy
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rxReady_q <= 1'b0;
    else
      rxReady_q <= !frameDone && !cmdPend_q
                && st_q == sbcp_pkg::EX_IDLE;
  end

  // three-state control of the sensor interface
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tri_q <= sbcp_pkg::TRI_RESET;
    else if (exec && f_q[0] == sbcp_pkg::OP_SETTING
             && f_q[1] == sbcp_pkg::FEAT_TRI)
      tri_q <= !isTriOff;
  end

  // continuous acquisition session
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      running_q <= 1'b0;
    else if (exec && f_q[0] == sbcp_pkg::OP_ACQ
             && f_q[1] == sbcp_pkg::ACQ_SUB)
    begin
      if (f_q[2] == sbcp_pkg::ACQ_RUN && f_q[3] == sbcp_pkg::ACQ_RUN)
        running_q <= 1'b1;
      else if (isStop)
        running_q <= 1'b0;
    end
  end

  // executor: register access, sampling, reply transmit
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= sbcp_pkg::EX_IDLE;
      mode_q <= sbcp_pkg::MD_BYTE;
      regAddr_q <= 8'h00;
      regWrData_q <= 8'h00;
      regWrEn_q <= 1'b0;
      regRdEn_q <= 1'b0;
      sampleReq_q <= 1'b0;
      rdHold_q <= 8'h00;
      txIdx_q <= 4'h0;
      txValid_q <= 1'b0;
      txData_q <= 8'h00;
      for (int i = 0; i < 9; i++)
        rbuf_q[i] <= sbcp_pkg::FILL_BYTE;
    end
    else
    begin
      regWrEn_q <= 1'b0;
      regRdEn_q <= 1'b0;
      sampleReq_q <= 1'b0;
      unique case (st_q)
        sbcp_pkg::EX_IDLE:
          if (cmdPend_q)
          begin
            regAddr_q <= f_q[1];
            if (f_q[0] == sbcp_pkg::OP_BYTE_WR)
            begin
              mode_q <= sbcp_pkg::MD_BYTE;
              regWrData_q <= f_q[2];
              regWrEn_q <= 1'b1;
              st_q <= sbcp_pkg::EX_WR;
            end
            else if (f_q[0] == sbcp_pkg::OP_BIT_WR
                     && (f_q[3] == sbcp_pkg::BIT_HIGH
                         || f_q[3] == sbcp_pkg::BIT_LOW))
            begin
              mode_q <= sbcp_pkg::MD_BITW;
              regRdEn_q <= 1'b1;
              st_q <= sbcp_pkg::EX_RDW;
            end
            else if (f_q[0] == sbcp_pkg::OP_BYTE_RD
                     || f_q[0] == sbcp_pkg::OP_BIT_RD)
            begin
              mode_q <= f_q[0] == sbcp_pkg::OP_BYTE_RD
                      ? sbcp_pkg::MD_BYTE : sbcp_pkg::MD_BIT;
              regRdEn_q <= 1'b1;
              st_q <= sbcp_pkg::EX_RDW;
            end
            else if (f_q[0] == sbcp_pkg::OP_ACQ
                     && f_q[1] == sbcp_pkg::ACQ_SUB
                     && f_q[2] == sbcp_pkg::ACQ_ONE_A
                     && f_q[3] == sbcp_pkg::ACQ_ONE_B)
            begin
              sampleReq_q <= 1'b1;
              st_q <= sbcp_pkg::EX_SMPW;
            end
          end
          else if (running_q)
          begin
            sampleReq_q <= 1'b1;
            st_q <= sbcp_pkg::EX_SMPW;
          end
        sbcp_pkg::EX_RDW:
          if (regRdValid)
          begin
            rdHold_q <= regRdData;
            if (mode_q == sbcp_pkg::MD_BITW)
            begin
              regWrData_q <= regRdData;
              regWrData_q[f_q[2][2:0]] <= f_q[3] == sbcp_pkg::BIT_HIGH;
              regWrEn_q <= 1'b1;
              st_q <= sbcp_pkg::EX_WR;
            end
            else if (mode_q == sbcp_pkg::MD_BYTE)
            begin
              rbuf_q[0] <= sbcp_pkg::RD_MARK_HI;
              rbuf_q[1] <= sbcp_pkg::RD_MARK_LO;
              rbuf_q[2] <= regRdData;
              rbuf_q[3] <= regAddr_q;
              for (int i = 4; i < 9; i++)
                rbuf_q[i] <= sbcp_pkg::FILL_BYTE;
              st_q <= sbcp_pkg::EX_SEND;
            end
            else
            begin
              for (int i = 0; i < 8; i++)
                rbuf_q[i] <= {7'h00, regRdData[7 - i]};
              rbuf_q[8] <= regRdData;
              st_q <= sbcp_pkg::EX_SEND;
            end
            txIdx_q <= 4'h0;
          end
        sbcp_pkg::EX_WR:
          st_q <= sbcp_pkg::EX_IDLE;
        sbcp_pkg::EX_SMPW:
          if (sampleValid)
          begin
            mode_q <= sbcp_pkg::MD_SMP;
            rbuf_q[0] <= sbcp_pkg::SMP_HDR_HI;
            rbuf_q[1] <= sbcp_pkg::SMP_HDR_LO;
            rbuf_q[2] <= accelX[15:8];
            rbuf_q[3] <= accelX[7:0];
            rbuf_q[4] <= accelY[15:8];
            rbuf_q[5] <= accelY[7:0];
            rbuf_q[6] <= accelZ[15:8];
            rbuf_q[7] <= accelZ[7:0];
            rbuf_q[8] <= {6'h00, buttons};
            txIdx_q <= 4'h0;
            st_q <= sbcp_pkg::EX_SEND;
          end
        sbcp_pkg::EX_SEND:
          if (!txValid_q || txReady)
          begin
            if (txIdx_q < sbcp_pkg::REPLY_LEN)
            begin
              txValid_q <= 1'b1;
              txData_q <= rbuf_q[txIdx_q];
              txIdx_q <= txIdx_q + 4'h1;
            end
            else
            begin
              txValid_q <= 1'b0;
              st_q <= sbcp_pkg::EX_IDLE;
            end
          end
      endcase
    end
  end

  chk_sep_resync: assert property (@(posedge sys_clk) disable iff (srst)
    take && ps_q == sbcp_pkg::PS_SEP1 && rxData != sbcp_pkg::SEP_SECOND
    |=> ps_q != sbcp_pkg::PS_FIELD)
    else $error("field taken without full separator");
  chk_write_store: assert property (@(posedge sys_clk) disable iff (srst)
    exec && f_q[0] == sbcp_pkg::OP_BYTE_WR
    |=> regWrEn_q && regWrData_q == $past(f_q[2])
        && regAddr_q == $past(f_q[1]) ##1 !regWrEn_q)
    else $error("byte write not issued");
  chk_bit_keep: assert property (@(posedge sys_clk) disable iff (srst)
    regWrEn_q && mode_q == sbcp_pkg::MD_BITW
    |-> ((regWrData_q ^ rdHold_q) & ~(8'h01 << f_q[2][2:0])) == 8'h00)
    else $error("bit write disturbed other bits");
  chk_bit_value: assert property (@(posedge sys_clk) disable iff (srst)
    regWrEn_q && mode_q == sbcp_pkg::MD_BITW
    |-> regWrData_q[f_q[2][2:0]] == (f_q[3] == sbcp_pkg::BIT_HIGH))
    else $error("bit write value wrong");
  chk_rd_reply: assert property (@(posedge sys_clk) disable iff (srst)
    st_q == sbcp_pkg::EX_SEND && mode_q == sbcp_pkg::MD_BYTE
    |-> rbuf_q[0] == sbcp_pkg::RD_MARK_HI && rbuf_q[2] == rdHold_q
        && rbuf_q[3] == regAddr_q)
    else $error("read reply malformed");
  chk_bit_order: assert property (@(posedge sys_clk) disable iff (srst)
    st_q == sbcp_pkg::EX_SEND && mode_q == sbcp_pkg::MD_BIT
    |-> rbuf_q[0][0] == rdHold_q[7] && rbuf_q[7][0] == rdHold_q[0]
        && rbuf_q[8] == rdHold_q)
    else $error("bit reply order wrong");
  chk_tri_clear: assert property (@(posedge sys_clk) disable iff (srst)
    exec && isTriOff |=> !tri_q)
    else $error("three-state not released");
  chk_stop_run: assert property (@(posedge sys_clk) disable iff (srst)
    exec && isStop |=> !running_q)
    else $error("stop did not end session");
  chk_smp_reply: assert property (@(posedge sys_clk) disable iff (srst)
    st_q == sbcp_pkg::EX_SMPW && sampleValid
    |=> rbuf_q[1] == sbcp_pkg::SMP_HDR_LO
        && rbuf_q[8][1:0] == $past(buttons))
    else $error("sample reply malformed");
  chk_one_sample: assert property (@(posedge sys_clk) disable iff (srst)
    sampleReq_q |=> !sampleReq_q)
    else $error("sample request longer than a cycle");
endmodule
`default_nettype wire

// ### design/sbcp_pkg.sv
// constants and types of the sensor board command parser
// Summary of operation
// - four fields, each after separator 65 6B
// - operation_code 77 writes data byte to address
// - operation_code 57 changes one register bit only
// - bit value 74 sets, 66 clears
// - operation_code 72 reads addressed register
// - read reply 52 56, data, address, five
// - operation_code 52 reads register for bit report
// - bit reply bits 7 to 0, then data
// - operation_code 53 field one selects feature
// - feature 41 is interface three-state control
// - 4F 6F 75 61 sends one sample
// - 4F 6F 6E 6E samples continuously until stop
// - 4F 6F 66 66 stops sampling
// - sample reply 73 74, XYZ high/low, service
// - service bits 1:0 are push-buttons
package sbcp_pkg;
  localparam logic [7:0] SEP_FIRST    = 8'h65;
  localparam logic [7:0] SEP_SECOND   = 8'h6B;
  localparam logic [7:0] OP_BYTE_WR   = 8'h77;
  localparam logic [7:0] OP_BIT_WR    = 8'h57;
  localparam logic [7:0] OP_BYTE_RD   = 8'h72;
  localparam logic [7:0] OP_BIT_RD    = 8'h52;
  localparam logic [7:0] OP_SETTING   = 8'h53;
  localparam logic [7:0] OP_ACQ       = 8'h4F;
  localparam logic [7:0] ACQ_SUB      = 8'h6F;
  localparam logic [7:0] BIT_HIGH     = 8'h74;
  localparam logic [7:0] BIT_LOW      = 8'h66;
  localparam logic [7:0] FEAT_TRI     = 8'h41;
  localparam logic [7:0] TRI_OFF_VAL  = 8'h30;
  localparam logic [7:0] ACQ_ONE_A    = 8'h75;
  localparam logic [7:0] ACQ_ONE_B    = 8'h61;
  localparam logic [7:0] ACQ_RUN      = 8'h6E;
  localparam logic [7:0] ACQ_STOP     = 8'h66;
  localparam logic [7:0] RD_MARK_HI   = 8'h52;
  localparam logic [7:0] RD_MARK_LO   = 8'h56;
  localparam logic [7:0] SMP_HDR_HI   = 8'h73;
  localparam logic [7:0] SMP_HDR_LO   = 8'h74;
  localparam logic [7:0] FILL_BYTE    = 8'h00;
  localparam logic [3:0] REPLY_LEN    = 4'h9;
  localparam logic       TRI_RESET    = 1'b1;
  typedef enum logic [2:0] {
    PS_SEP0  = 3'b001,
    PS_SEP1  = 3'b010,
    PS_FIELD = 3'b100
  } sbcp_pstate_t;
  typedef enum logic [4:0] {
    EX_IDLE = 5'b00001,
    EX_RDW  = 5'b00010,
    EX_WR   = 5'b00100,
    EX_SMPW = 5'b01000,
    EX_SEND = 5'b10000
  } sbcp_xstate_t;
  typedef enum logic [1:0] {
    MD_BYTE = 2'h0,
    MD_BIT  = 2'h1,
    MD_BITW = 2'h2,
    MD_SMP  = 2'h3
  } sbcp_mode_t;
endpackage

// ### tb/sbcp_sensor_model.sv
// behavioural sensor: register file and acceleration source
`timescale 1ns/1ps
`default_nettype none
module sbcp_sensor_model #(
  parameter logic [15:0] AX = 16'h1A2B,
  parameter logic [15:0] AY = 16'h3C4D,
  parameter logic [15:0] AZ = 16'h5E6F
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  input  wire logic        sampleReq,
  output logic      [15:0] accelX,
  output logic      [15:0] accelY,
  output logic      [15:0] accelZ,
  output logic             sampleValid
);
  logic [7:0] mem [256];
  logic [2:0] rdCnt;
  logic [2:0] smpCnt;

  always_ff @(posedge sys_clk)
  begin
    if (regWrEn)
      mem[regAddr] <= regWrData;
  end

  // reads answer after three cycles; idle data toggles
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdCnt <= 3'h0;
    else if (regRdEn)
      rdCnt <= 3'h3;
    else if (rdCnt != 3'h0)
      rdCnt <= rdCnt - 3'h1;
    regRdValid <= !srst && rdCnt == 3'h1;
    if (srst)
      regRdData <= 8'h5A;
    else
      regRdData <= (rdCnt == 3'h1) ? mem[regAddr] : ~regRdData;
  end

  // samples answer slowly, after five cycles
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      smpCnt <= 3'h0;
    else if (sampleReq)
      smpCnt <= 3'h5;
    else if (smpCnt != 3'h0)
      smpCnt <= smpCnt - 3'h1;
    sampleValid <= !srst && smpCnt == 3'h1;
    if (srst)
      accelX <= 16'hA5A5;
    else
      accelX <= (smpCnt == 3'h1) ? AX : ~accelX;
    accelY <= (smpCnt == 3'h1) ? AY : ~accelX;
    accelZ <= (smpCnt == 3'h1) ? AZ : accelX;
  end
endmodule
`default_nettype wire

// ### tb/sbcp_parser_tb.sv
// self-checking bench of the command parser
`timescale 1ns/1ps
`default_nettype none
module sbcp_parser_tb;
  localparam logic [15:0] AX = 16'h1A2B;
  localparam logic [15:0] AY = 16'h3C4D;
  localparam logic [15:0] AZ = 16'h5E6F;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic [7:0]  rxData  = 8'h00;
  logic        rxValid = 1'b0;
  logic        txReady = 1'b1;
  logic [1:0]  buttons = 2'b00;
  logic        rxReady, txValid, regWrEn, regRdEn, regRdValid;
  logic        sampleReq, sampleValid, spiTristate;
  logic [7:0]  txData, regAddr, regWrData, regRdData;
  logic [15:0] accelX, accelY, accelZ;
  int          errTotal = 0;
  int          checks   = 0;
  int          txCount  = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (txValid === 1'b1 && txReady) txCount <= txCount + 1;

  sbcp_parser DUT (.sys_clk(sys_clk), .srst(srst), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .sampleReq(sampleReq), .accelX(accelX), .accelY(accelY),
    .accelZ(accelZ), .sampleValid(sampleValid), .buttons(buttons),
    .spiTristate(spiTristate));

  sbcp_sensor_model #(.AX(AX), .AY(AY), .AZ(AZ)) sensor (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .sampleReq(sampleReq), .accelX(accelX), .accelY(accelY),
    .accelZ(accelZ), .sampleValid(sampleValid));

  task automatic chk8(input string name, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      errTotal++;
      $display("[FAIL] %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic test_done;
    if (errTotal == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // offered at a falling edge, taken at the rising edge after
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rxData = b;
    rxValid = 1'b1;
    while (rxReady !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk1("rxReady", 1'b1, rxReady);
    @(negedge sys_clk);
  endtask

  task automatic frame(input logic [7:0] op, f1, f2, f3);
    logic [7:0] fld [4];
    fld = '{op, f1, f2, f3};
    foreach (fld[i])
    begin
      send(8'h65);
      send(8'h6B);
      send(fld[i]);
    end
    rxValid = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic take(output logic [7:0] b);
    int n;
    n = 0;
    while (txValid !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk1("txValid", 1'b1, txValid);
    b = txData;
    @(negedge sys_clk);
  endtask

  task automatic getb(input string name, input logic [7:0] e);
    logic [7:0] b;
    take(b);
    chk8(name, e, b);
  endtask

  task automatic read_reply(input logic [7:0] d, input logic [7:0] a);
    logic [7:0] b;
    getb("mark_hi", 8'h52);
    getb("mark_lo", 8'h56);
    getb("reg_data", d);
    getb("reg_addr", a);
    repeat (5) take(b);
  endtask

  task automatic sample_reply(input logic [1:0] btn);
    getb("hdr_hi", 8'h73);
    getb("hdr_lo", 8'h74);
    getb("x_hi", AX[15:8]);
    getb("x_lo", AX[7:0]);
    getb("y_hi", AY[15:8]);
    getb("y_lo", AY[7:0]);
    getb("z_hi", AZ[15:8]);
    getb("z_lo", AZ[7:0]);
    getb("service", {6'h00, btn});
  endtask

  // waits for a silent reply stream and returns the byte count
  task automatic quiet(output int n);
    int q;
    int k;
    q = 0;
    k = 0;
    while (q < 20 && k < 3000)
    begin
      @(negedge sys_clk);
      q = (txValid === 1'b1) ? 0 : q + 1;
      k++;
    end
    n = txCount;
  endtask

  task automatic t_byte_rw;
    frame(8'h77, 8'h20, 8'hA5, 8'h3C);
    frame(8'h72, 8'h20, 8'h11, 8'h22);
    read_reply(8'hA5, 8'h20);
  endtask

  task automatic t_bits;
    logic [7:0] v;
    v = 8'h27;
    frame(8'h57, 8'h20, 8'h01, 8'h74);
    frame(8'h57, 8'h20, 8'h07, 8'h66);
    frame(8'h57, 8'h20, 8'h03, 8'h55);
    frame(8'h52, 8'h20, 8'h00, 8'h00);
    for (int i = 7; i >= 0; i--)
      getb("bit", {7'h00, v[i]});
    getb("bit_data", v);
  endtask

  task automatic t_setting;
    int n;
    chk1("tri_reset", 1'b1, spiTristate);
    frame(8'h53, 8'h41, 8'h30, 8'h30);
    quiet(n);
    chk1("tri_off", 1'b0, spiTristate);
    frame(8'h53, 8'h42, 8'h31, 8'h31);
    quiet(n);
    chk1("tri_other", 1'b0, spiTristate);
    frame(8'h53, 8'h41, 8'h31, 8'h30);
    quiet(n);
    chk1("tri_on", 1'b1, spiTristate);
    frame(8'h53, 8'h41, 8'h30, 8'h30);
    quiet(n);
    chk1("tri_off2", 1'b0, spiTristate);
  endtask

  task automatic t_single;
    int n;
    buttons = 2'b10;
    frame(8'h4F, 8'h6F, 8'h75, 8'h61);
    sample_reply(2'b10);
    quiet(n);
    repeat (200) @(negedge sys_clk);
    chk8("single_count", n[7:0], txCount[7:0]);
  endtask

  task automatic t_cont;
    int n;
    buttons = 2'b01;
    frame(8'h4F, 8'h6F, 8'h6E, 8'h6E);
    sample_reply(2'b01);
    sample_reply(2'b01);
    frame(8'h4F, 8'h6F, 8'h66, 8'h66);
    quiet(n);
    repeat (300) @(negedge sys_clk);
    chk8("stop_count", n[7:0], txCount[7:0]);
    chk1("whole_reply", 1'b1, (txCount % 9) == 0);
  endtask

  // reply held while the host refuses it
  task automatic t_stall;
    txReady = 1'b0;
    frame(8'h72, 8'h20, 8'h00, 8'h00);
    repeat (20) @(negedge sys_clk);
    chk1("stall_valid", 1'b1, txValid);
    chk8("stall_data", 8'h52, txData);
    txReady = 1'b1;
    read_reply(8'h27, 8'h20);
  endtask

  task automatic t_resync;
    int n;
    logic [7:0] junk [9];
    junk = '{8'h65, 8'h00, 8'h65, 8'h6B, 8'h72, 8'h00, 8'h65, 8'h6B, 8'h99};
    quiet(n);
    foreach (junk[i])
      send(junk[i]);
    frame(8'h72, 8'h20, 8'h00, 8'h00);
    read_reply(8'h27, 8'h20);
    repeat (200) @(negedge sys_clk);
    chk8("resync_count", 8'(n + 9), txCount[7:0]);
  endtask

  initial
  begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_setting();
    t_byte_rw();
    t_bits();
    t_single();
    t_cont();
    t_stall();
    t_resync();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    errTotal++;
    test_done();
  end
endmodule
`default_nettype wire
